// [aocr_pkg.sv]
// aocr_pkg: constants and types of the converter output configuration block
package aocr_pkg;
   // ==========================================================
   // register indexes (byte address is four times the index)
   localparam logic [7:0] IDX_PATTERN = 8'h65;
   localparam logic [7:0] IDX_GAIN = 8'h68;
   localparam logic [7:0] IDX_USER_LO = 8'h69;
   localparam logic [7:0] IDX_USER_HI = 8'h6a;
   localparam logic [7:0] IDX_OUT_IF = 8'h6c;
   localparam logic [7:0] IDX_REF = 8'h6d;
   localparam logic [7:0] IDX_SRST = 8'h6e;
   localparam int AOCR_AW = 12;
   // ==========================================================
   // field positions
   localparam int PAT_LSB = 5;
   localparam int GAIN_LSB = 0;
   localparam int OUT_IF_LSB = 3;
   localparam int REF_BIT = 4;
   localparam int SRST_BIT = 0;
   // ==========================================================
   // reset values and codes
   localparam logic [3:0] GAIN_RESET = 4'h9;
   localparam logic [1:0] OUT_IF_PIN = 2'h0;
   localparam logic [1:0] OUT_IF_LVDS = 2'h1;
   localparam logic [1:0] OUT_IF_CMOS = 2'h3;
   localparam logic [2:0] GAIN_DB_ONE = 3'h1;
   localparam logic [15:0] TOGGLE_WORD = 16'haaaa;
   localparam logic [15:0] RAMP_MAX = 16'hffff;
   localparam logic [15:0] ALL_ZERO = 16'h0000;
   localparam logic [15:0] ALL_ONE = 16'hffff;
   localparam int SAMPLE_W = 16;
   localparam int FIFO_DEPTH = 32;
   // ==========================================================
   // test pattern selector codes
   typedef enum logic [2:0] {
      PAT_NORMAL = 3'b000,
      PAT_ZEROS = 3'b001,
      PAT_ONES = 3'b010,
      PAT_TOGGLE = 3'b011,
      PAT_RAMP = 3'b100,
      PAT_USER = 3'b101,
      PAT_SPARE = 3'b110,
      PAT_UNUSED = 3'b111
   } aocr_pat_type;
   // ==========================================================
   // configuration state carried as one struct
   typedef struct packed {
      aocr_pat_type pattern;
      logic [3:0] gain;
      logic [7:0] user_lo;
      logic [7:0] user_hi;
      logic [1:0] out_if;
      logic ext_ref;
      logic srst;
   } aocr_cfg_type;
   localparam aocr_cfg_type CFG_RESET = '{
      pattern: PAT_NORMAL,
      gain: GAIN_RESET,
      user_lo: 8'h00,
      user_hi: 8'h00,
      out_if: OUT_IF_PIN,
      ext_ref: 1'b0,
      srst: 1'b0
   };
endpackage

// [aocr_top.sv]
// aocr_top: output configuration registers, pattern source and output fifo
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
// ==========================================================
// Summary of operation
// [R1] selector 000 samples, 001 zeros, 010 ones
// [R2] code 011 gives alternating toggle pattern
// [R3] code 100 ramps up one code per sample
// [R4] ramp wraps from maximum back to zero
// [R5] code 101 outputs the custom pattern word
// [R6] low custom register gives bits 7..0
// [R7] high custom register gives bits 15..8
// [R8] fine gain decode, reset 1 dB
// [R9] interface code 00 follows format pin
// [R10] interface code 01 forces ddr lvds
// [R11] interface code 11 forces parallel cmos
// [R12] reference bit selects internal or external
// [R13] soft reset restores every register default
// [R14] pattern selector lives at index 65
// [R15] soft reset bit clears itself afterwards

// ==========================================================
// fifo: parameterised first-in first-out buffer
module aocr_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);
   // storage array
   logic [WIDTH-1:0] mem [DEPTH];
   // pointers carry one extra wrap bit
   logic [PW:0] wr_r;
   logic [PW:0] wr_nxt;
   logic [PW:0] rd_r;
   logic [PW:0] rd_nxt;
   logic push;
   logic pop;
   logic full;
   logic empty;

   // full when the pointers differ only in the wrap bit
   assign full = (wr_r[PW] != rd_r[PW]) &&
                 (wr_r[PW-1:0] == rd_r[PW-1:0]);
   assign empty = (wr_r == rd_r);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;
   // read port comes straight from the array word
   assign out_data = mem[rd_r[PW-1:0]];

   // next pointer values
   always_comb
   begin
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      if (push)
      begin
         wr_nxt = wr_r + 1'b1;
      end
      if (pop)
      begin
         rd_nxt = rd_r + 1'b1;
      end
   end

   // pointer registers
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         wr_r <= '0;
         rd_r <= '0;
      end
      else
      begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
   end

   // the array needs no reset; empty hides stale words
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem[wr_r[PW-1:0]] <= in_data;
      end
   end
endmodule // aocr_fifo

// ==========================================================
// top: apb slave, pattern generator, output path
module aocr_top
   import aocr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AOCR_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converted samples from the core
   input wire logic [SAMPLE_W-1:0] sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   // interface strap pin, high asks for lvds
   input wire logic format_select_pin,
   // output words toward the capture device
   output logic [SAMPLE_W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   // analog side controls
   output logic lvds_mode,
   output logic ext_ref_mode,
   output logic [2:0] gain_db
);
   // ==========================================================
   // declarations
   aocr_cfg_type cfg_r; // configuration registers
   aocr_cfg_type cfg_nxt;
   logic [31:0] prdata_r; // read data latched in setup
   logic [31:0] prdata_nxt;
   logic pslverr_r; // unmapped flag latched in setup
   logic pslverr_nxt;
   logic [15:0] ramp_r; // ramp counter
   logic [15:0] ramp_nxt;
   logic [15:0] tog_r; // toggle word, flips each push while code 011 is selected
   logic [15:0] tog_nxt;
   logic lvds_r; // interface choice to the pads
   logic lvds_nxt;
   logic [2:0] gain_db_r; // decoded gain in dB
   logic [2:0] gain_db_nxt;
   logic [7:0] idx; // register index from the address
   logic hit; // address maps onto a register
   logic wr_en; // write completes this cycle
   logic [15:0] src_data; // word entering the fifo
   logic src_valid;
   logic fifo_ready;
   logic src_push;
   logic [15:0] user_word;
   logic live; // core samples are selected

   // ==========================================================
   // address decode
   // word aligned: low two bits are ignored
   assign idx = paddr[9:2];
   always_comb
   begin
      hit = 1'b0;
      case (idx)
         IDX_PATTERN, IDX_GAIN, IDX_USER_LO,
         IDX_USER_HI, IDX_OUT_IF, IDX_REF,
         IDX_SRST: hit = (paddr[AOCR_AW-1:10] == '0);
         default: hit = 1'b0;
      endcase
   end

   // zero wait state: every access phase completes
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign wr_en = psel && penable && pwrite && hit;

   // ==========================================================
   // read data and error, captured during the setup cycle
   // so the data output comes from a flip-flop
   always_comb
   begin
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      if (psel && !penable)
      begin
         prdata_nxt = 32'h0000_0000;
         pslverr_nxt = !hit;
         if (!pwrite)
         begin
            case (idx)
               IDX_PATTERN: prdata_nxt[PAT_LSB +: 3] = cfg_r.pattern; // R14
               IDX_GAIN: prdata_nxt[GAIN_LSB +: 4] = cfg_r.gain;
               IDX_USER_LO: prdata_nxt[7:0] = cfg_r.user_lo;
               IDX_USER_HI: prdata_nxt[7:0] = cfg_r.user_hi;
               IDX_OUT_IF: prdata_nxt[OUT_IF_LSB +: 2] = cfg_r.out_if;
               IDX_REF: prdata_nxt[REF_BIT] = cfg_r.ext_ref;
               IDX_SRST: prdata_nxt[SRST_BIT] = cfg_r.srst;
               default: prdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   // bus answer registers
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ==========================================================
   // configuration registers
   // a pending soft reset wins over any write in the same cycle
   always_comb
   begin
      cfg_nxt = cfg_r;
      if (cfg_r.srst)
      begin
         // one cycle after the write all fields go default,
         // srst itself included so it clears
         cfg_nxt = CFG_RESET; // R13 R15
      end
      else if (wr_en)
      begin
         case (idx)
            IDX_PATTERN: // R14
               cfg_nxt.pattern = aocr_pat_type'(pwdata[PAT_LSB +: 3]);
            IDX_GAIN: cfg_nxt.gain = pwdata[GAIN_LSB +: 4];
            IDX_USER_LO: cfg_nxt.user_lo = pwdata[7:0]; // R6
            IDX_USER_HI: cfg_nxt.user_hi = pwdata[7:0]; // R7
            IDX_OUT_IF: cfg_nxt.out_if = pwdata[OUT_IF_LSB +: 2];
            IDX_REF: cfg_nxt.ext_ref = pwdata[REF_BIT]; // R12
            IDX_SRST: cfg_nxt.srst = pwdata[SRST_BIT]; // R13
            default: cfg_nxt = cfg_r;
         endcase
      end
   end

   // configuration flip-flops
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         cfg_r <= CFG_RESET;
      end
      else
      begin
         cfg_r <= cfg_nxt;
      end
   end

   // ==========================================================
   // pattern source
   // custom word assembled from the two byte registers
   assign user_word = {cfg_r.user_hi, cfg_r.user_lo}; // R6 R7

   // samples pass on 000 and on the two unused codes
   assign live = (cfg_r.pattern == PAT_NORMAL) ||
      (cfg_r.pattern == PAT_SPARE) || (cfg_r.pattern == PAT_UNUSED);
   // test patterns are always valid; normal mode waits on
   // the core and passes fifo back-pressure to it
   assign src_valid = live ? sample_valid : 1'b1;
   always_comb
   begin
      case (cfg_r.pattern)
         PAT_ZEROS: src_data = ALL_ZERO; // R1
         PAT_ONES: src_data = ALL_ONE; // R1
         PAT_TOGGLE: src_data = tog_r; // R2
         PAT_RAMP: src_data = ramp_r; // R3
         PAT_USER: src_data = user_word; // R5
         // normal and unused codes fall back to live samples
         default: src_data = sample_data; // R1
      endcase
   end

   assign src_push = src_valid && fifo_ready;
   // core only sees ready while its samples are selected
   assign sample_ready = fifo_ready && live;

   // ramp and toggle advance only on words the fifo took,
   // so a stalled reader never sees a skipped code
   always_comb
   begin
      ramp_nxt = ramp_r;
      tog_nxt = tog_r;
      if (cfg_r.pattern != PAT_RAMP)
      begin
         ramp_nxt = ALL_ZERO; // ramp restarts from zero
      end
      else if (src_push)
      begin
         if (ramp_r == RAMP_MAX)
         begin
            ramp_nxt = ALL_ZERO; // R4
         end
         else
         begin
            ramp_nxt = ramp_r + 16'h0001; // R3
         end
      end
      if (cfg_r.pattern != PAT_TOGGLE)
      begin
         tog_nxt = TOGGLE_WORD;
      end
      else if (src_push)
      begin
         tog_nxt = ~tog_r; // R2
      end
   end

   // pattern state flip-flops
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         ramp_r <= ALL_ZERO;
         tog_r <= TOGGLE_WORD;
      end
      else
      begin
         ramp_r <= ramp_nxt;
         tog_r <= tog_nxt;
      end
   end

   // ==========================================================
   // output fifo toward the capture device
   aocr_fifo
   #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   )
   u_fifo
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .in_data(src_data),
      .in_valid(src_valid),
      .in_ready(fifo_ready),
      .out_data(out_data),
      .out_valid(out_valid),
      .out_ready(out_ready)
   );

   // ==========================================================
   // interface choice and gain decode
   always_comb
   begin
      case (cfg_r.out_if)
         OUT_IF_PIN: lvds_nxt = format_select_pin; // R9
         OUT_IF_LVDS: lvds_nxt = 1'b1; // R10
         OUT_IF_CMOS: lvds_nxt = 1'b0; // R11
         default: lvds_nxt = format_select_pin;
      endcase
      // top bit clear and code 1111 both give 1 dB
      if (!cfg_r.gain[3] || (cfg_r.gain == 4'hf))
      begin
         gain_db_nxt = GAIN_DB_ONE; // R8
      end
      else
      begin
         gain_db_nxt = cfg_r.gain[2:0]; // R8
      end
   end

   // pad control flip-flops
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         lvds_r <= 1'b0;
         gain_db_r <= GAIN_DB_ONE;
      end
      else
      begin
         lvds_r <= lvds_nxt;
         gain_db_r <= gain_db_nxt;
      end
   end

   assign lvds_mode = lvds_r;
   assign gain_db = gain_db_r;
   assign ext_ref_mode = cfg_r.ext_ref; // R12
endmodule // aocr_top

// [aocr_sva.sv]
// checker on the ports of the output configuration block
`timescale 1ns/100ps
module aocr_sva import aocr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AOCR_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic sample_ready,
   input wire logic format_select_pin,
   input wire logic lvds_mode,
   input wire logic ext_ref_mode,
   input wire logic [2:0] gain_db
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // shadow of the fields that reach the ports
   aocr_cfg_type m_r, m_nxt; // mirrored configuration
   logic [2:0] gdb_r, gdb_nxt; // expected decoded gain
   logic wr, mapped; // write taken, address decodes
   assign wr = psel && penable && pwrite && paddr[11:10] == 2'h0;
   assign mapped = paddr[11:10] == 2'h0 && paddr[9:2] inside {IDX_PATTERN,
      IDX_GAIN, IDX_USER_LO, IDX_USER_HI, IDX_OUT_IF, IDX_REF, IDX_SRST};
   // next shadow; soft reset wins over a write in its cycle
   always_comb
   begin
      m_nxt = m_r;
      gdb_nxt = GAIN_DB_ONE;
      if (m_r.gain[3] && m_r.gain != 4'hf)
         gdb_nxt = m_r.gain[2:0];
      if (m_r.srst)
         m_nxt = CFG_RESET;
      else if (wr)
         case (paddr[9:2])
            IDX_PATTERN: m_nxt.pattern = aocr_pat_type'(pwdata[7:5]);
            IDX_GAIN: m_nxt.gain = pwdata[3:0];
            IDX_OUT_IF: m_nxt.out_if = pwdata[4:3];
            IDX_REF: m_nxt.ext_ref = pwdata[REF_BIT];
            IDX_SRST: m_nxt.srst = pwdata[SRST_BIT];
            default: ;
         endcase
   end
   // registers only; reset is synchronous like the block's
   always_ff @(posedge clk_sys)
   begin
      m_r <= rstn ? m_nxt : CFG_RESET;
      gdb_r <= rstn ? gdb_nxt : GAIN_DB_ONE;
   end
   // ==========================================================
   // sequences and properties
   sequence s_srst;
      wr && paddr[9:2] == IDX_SRST && pwdata[SRST_BIT];
   endsequence
   sequence s_bad_setup;
      psel && !penable && !mapped;
   endsequence
   a_pat_stalls: assert property (
      m_r.pattern inside {[PAT_ZEROS:PAT_USER]} |-> !sample_ready)
      else $error("samples accepted during a test pattern");
   a_gain_decode: assert property (gain_db == gdb_r)
      else $error("decoded gain wrong");
   a_pin_decides: assert property (
      !m_r.out_if[0] |=> lvds_mode == $past(format_select_pin))
      else $error("interface does not follow the format pin");
   a_lvds_forced: assert property (
      m_r.out_if == OUT_IF_LVDS |=> lvds_mode)
      else $error("lvds not forced");
   a_cmos_forced: assert property (
      m_r.out_if == OUT_IF_CMOS |=> !lvds_mode)
      else $error("cmos not forced");
   a_ref_follows: assert property (ext_ref_mode == m_r.ext_ref)
      else $error("reference mode differs from its bit");
   a_srst_restore: assert property (
      s_srst |-> ##3 gain_db == GAIN_DB_ONE && !ext_ref_mode)
      else $error("soft reset left settings behind");
   a_unmapped_err: assert property (
      s_bad_setup |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (
      psel && !penable && mapped |=> !pslverr)
      else $error("mapped access refused");
endmodule // aocr_sva
bind aocr_top aocr_sva i_sva
(
   .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pslverr, .sample_ready, .format_select_pin, .lvds_mode,
   .ext_ref_mode, .gain_db
);

// [aocr_sink.sv]
// capture side model: takes output words, may stall
`timescale 1ns/100ps
module aocr_sink
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic hold,
   input wire logic slow,
   output logic out_ready
);
   int seed = 90038; // fixed start of the stall pattern
   initial
      out_ready = 1'b0;
   // ==========================================================
   // ready is held off, or is high only on random cycles, one in four on average, when slow
   always @(posedge clk_sys)
      out_ready <= rstn && !hold && (!slow || ($random(seed) & 3) == 0);
endmodule // aocr_sink

// [test_adc_output_config_registers.sv]
// self-checking bench for the output configuration block
`timescale 1ns/100ps
`define CHK(n, e, s) \
   begin \
      total_checks++; \
      if ((s) !== (e)) \
      begin \
         err_count++; \
         $display("[FAIL] %s exp %0h got %0h", n, e, s); \
      end \
   end
module test_adc_output_config_registers import aocr_pkg::*;;
   logic clk_sys, rstn, psel, penable, pwrite, sample_valid = 1'b0, er;
   logic format_select_pin, out_ready, hold, slow, sv_en;
   logic [AOCR_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, sample_ready, out_valid, lvds_mode, ext_ref_mode;
   logic [SAMPLE_W-1:0] sample_data = '0, out_data, usr;
   logic [2:0] gain_db;
   int err_count, total_checks, mode, rc, tg, pops, ex, i, k, n, xp;
   int mseen = -1; // pattern the model last saw a word of
   int seed = 90038;
   int sq[$]; // samples taken by the block, oldest first
   logic [7:0] ix[7] = '{IDX_PATTERN, IDX_GAIN, IDX_USER_LO, IDX_USER_HI,
      IDX_OUT_IF, IDX_REF, IDX_SRST};
   logic [31:0] dv[7] = '{32'h0, 32'h9, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] mk[7] = '{32'he0, 32'hf, 32'hff, 32'hff, 32'h18, 32'h10,
      32'h1};
   aocr_top i_dut
   (
      .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sample_data, .sample_valid, .sample_ready,
      .format_select_pin, .out_data, .out_valid, .out_ready, .lvds_mode,
      .ext_ref_mode, .gain_db
   );
   aocr_sink i_sink
   (
      .clk_sys, .rstn, .hold, .slow, .out_ready
   );
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // sample source: valid holds until taken
   always @(posedge clk_sys)
   begin
      if (sample_valid && sample_ready)
         sq.push_back(sample_data);
      if (!sample_valid || sample_ready)
      begin
         sample_valid <= sv_en && ($random(seed) & 1);
         sample_data <= $random(seed);
      end
   end
   // reference model of the output stream
   always @(posedge clk_sys)
      if (rstn && out_valid && out_ready)
      begin
         // first word of a newly selected pattern restarts the model
         if (mode != mseen)
         begin
            mseen = mode;
            rc = 0;
            tg = 0;
            pops = 0;
         end
         case (mode)
            0: ex = sq.size() ? sq.pop_front() : -1;
            1: ex = 0;
            2: ex = 16'hffff;
            3: ex = tg ? 16'h5555 : 16'haaaa;
            4: ex = rc;
            default: ex = usr;
         endcase
         `CHK("out_data", ex, out_data)
         tg = !tg;
         rc = (rc + 1) % 65536;
         pops++;
      end
   // ==========================================================
   // bus and stream tasks
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input bit w, input logic [7:0] a, input int d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, a, 2'h0};
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
      begin
         err_count++;
         end_sim;
      end
      @(posedge clk_sys);
   endtask
   task automatic setpat(input int p);
      mode = p > 5 ? 0 : p;
      apb(1'b1, IDX_PATTERN, p * 32);
   endtask
   // let the sink take every word, bounded
   task automatic drain;
      int n;
      n = 0;
      hold <= 1'b0;
      while (out_valid !== 1'b0 && n < 2000)
      begin
         @(posedge clk_sys);
         n++;
      end
      repeat (2) @(posedge clk_sys);
      hold <= 1'b1;
      `CHK("drained", 1, n < 2000)
   endtask
   // ==========================================================
   // main sequence
   initial
   begin
      {rstn, psel, penable, pwrite, format_select_pin, slow, sv_en, paddr,
         pwdata} = '0;
      hold = 1'b1;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      // defaults, read back, soft reset twice
      for (k = 0; k < 3; k++)
      begin
         for (i = 0; i < 7; i++)
         begin
            apb(1'b0, ix[i], 0);
            `CHK("default", dv[i], rd)
         end
         if (k == 2)
            break;
         for (i = 1; i < 6; i++)
         begin
            n = $random(seed);
            apb(1'b1, ix[i], n);
            apb(1'b0, ix[i], 0);
            `CHK("readback", n & mk[i], rd)
         end
         apb(1'b1, IDX_SRST, 1);
      end
      apb(1'b1, 8'h6b, -1);
      `CHK("refused", 1'b1, er)
      apb(1'b0, 8'h6b, 0);
      `CHK("unmapped", 32'h0, rd)
      for (i = 0; i < 16; i++)
      begin
         apb(1'b1, IDX_GAIN, i);
         repeat (2) @(posedge clk_sys);
         `CHK("gain", (i > 7 && i < 15) ? i - 8 : 1, gain_db)
      end
      for (i = 0; i < 8; i++)
      begin
         format_select_pin <= i % 2;
         apb(1'b1, IDX_OUT_IF, (i / 2) * 8);
         repeat (2) @(posedge clk_sys);
         xp = i / 2 == 1 ? 1 : i / 2 == 3 ? 0 : i % 2;
         `CHK("lvds", xp, lvds_mode)
      end
      for (i = 1; i >= 0; i--)
      begin
         apb(1'b1, IDX_REF, i * 16);
         `CHK("ref", i, ext_ref_mode)
      end
      // each test pattern fills the stalled buffer exactly
      usr = $random(seed);
      apb(1'b1, IDX_USER_LO, usr[7:0]);
      apb(1'b1, IDX_USER_HI, usr[15:8]);
      for (i = 1; i < 6; i++)
      begin
         setpat(i);
         apb(1'b0, IDX_PATTERN, 0);
         `CHK("pattern", i * 32, rd)
         repeat (40) @(posedge clk_sys);
         apb(1'b1, IDX_PATTERN, 0);
         drain;
         `CHK("words", FIFO_DEPTH, pops)
      end
      // samples pass with codes 111, 110 and 000, slow sink
      for (i = 7; i >= 0; i = (i == 6) ? 0 : i - 1)
      begin
         setpat(i);
         sv_en <= 1'b1;
         repeat (100) @(posedge clk_sys);
         `CHK("full", 1'b0, sample_ready)
         slow <= 1'b1;
         hold <= 1'b0;
         repeat (300) @(posedge clk_sys);
         sv_en <= 1'b0;
         drain;
         `CHK("left", 0, sq.size())
      end
      // long ramp run crosses the top code
      slow <= 1'b0;
      hold <= 1'b0;
      setpat(4);
      for (n = 0; pops < 65540 && n < 80000; n++)
         @(posedge clk_sys);
      `CHK("ramp run", 1, n < 80000)
      apb(1'b1, IDX_PATTERN, 0);
      drain;
      `CHK("wrap", 1, pops > 65536)
      end_sim;
   end
endmodule // test_adc_output_config_registers
